// [common/sfsc_pkg.sv]
// constants and state layout for the spi fault and slave-select control
package sfsc_pkg;

   // ----------------------------------------------------------------
   // slave-select mode encodings
   // ----------------------------------------------------------------
   localparam logic [1:0] SFSC_MODE_3WIRE = 2'h0;
   localparam logic [1:0] SFSC_MODE_4W_SLAVE = 2'h1;
   localparam logic [1:0] SFSC_MODE_4W_MST_LOW = 2'h2;
   localparam logic [1:0] SFSC_MODE_4W_MST_HIGH = 2'h3;

   // ----------------------------------------------------------------
   // counts, reset values and synchroniser lanes
   // ----------------------------------------------------------------
   localparam logic [2:0] SFSC_FIRST_BIT = 3'h0;
   localparam logic [2:0] SFSC_LAST_BIT = 3'h7;
   localparam logic [2:0] SFSC_BIT_STEP = 3'h1;
   localparam logic SFSC_FLAG_RESET = 1'b0;
   localparam logic SFSC_TXE_RESET = 1'b1;
   localparam logic SFSC_SS_OUT_RESET = 1'b1;
   localparam logic [7:0] SFSC_BYTE_RESET = 8'h00;
   // select lane parks high, clock lane low: no false edge after reset
   localparam logic [2:0] SFSC_SYNC_RESET = 3'h6;
   localparam logic SFSC_SCK_IDLE = 1'b0;
   localparam int SFSC_LANE_SCK = 0;
   localparam int SFSC_LANE_MOSI = 1;
   localparam int SFSC_LANE_SS = 2;

   // ----------------------------------------------------------------
   // whole state of the core bar the reset synchroniser
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [2:0] sync1;
      logic [2:0] sync2;
      logic sck_prev;
      logic [2:0] bit_cnt;
      logic [7:0] rx_shift;
      logic [7:0] rx_data;
      logic rx_full;
      logic [7:0] tx_hold;
      logic tx_pending;
      logic [7:0] tx_shift;
      logic mode_fault;
      logic overrun;
      logic txe;
      logic irq;
      logic ss_out;
      logic ss_oe;
      logic miso;
      logic miso_oe;
   } sfsc_state_t;

endpackage

// [rtl/sfsc_core.sv]
// fault flags, slave-select pin control and slave byte path
module sfsc_core
   import sfsc_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [1:0] slave_select_mode_field,
   input wire logic master_enable_bit,
   input wire logic interrupt_enable,
   input wire logic flag_write,
   input wire logic flag_write_mode_fault,
   input wire logic flag_write_overrun,
   input wire logic rx_read,
   input wire logic tx_write,
   input wire logic [7:0] tx_data,
   input wire logic sck_in,
   input wire logic mosi_in,
   input wire logic slave_select_pin_in,
   output logic slave_select_pin_out,
   output logic slave_select_pin_oe,
   output logic miso_out,
   output logic miso_oe,
   output logic mode_fault_flag,
   output logic receive_overrun_flag,
   output logic transmit_buffer_empty_status,
   output logic [7:0] rx_data,
   output logic rx_full,
   output logic interrupt_request
);

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic rst_meta;
   logic rst_n;

   // release is synchronised so no flop leaves reset a cycle early
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   sfsc_state_t st;
   sfsc_state_t next_st;
   logic sck_rise;
   logic sck_fall;
   logic ss_low;
   logic selected;
   logic collision;
   logic last_bit;
   logic [7:0] rx_byte;
   logic buf_busy;

   // decode of the synchronised pins; only stage two is looked at
   always_comb begin
      sck_rise = st.sync2[SFSC_LANE_SCK] && !st.sck_prev;
      sck_fall = !st.sync2[SFSC_LANE_SCK] && st.sck_prev;
      ss_low = !st.sync2[SFSC_LANE_SS];
      collision = (slave_select_mode_field == SFSC_MODE_4W_SLAVE)
         && master_enable_bit && ss_low;
      // three-wire slave is always selected; four-wire needs select low
      selected = !master_enable_bit
         && ((slave_select_mode_field == SFSC_MODE_3WIRE)
         || ((slave_select_mode_field == SFSC_MODE_4W_SLAVE) && ss_low));
      last_bit = selected && sck_rise && (st.bit_cnt == SFSC_LAST_BIT);
      rx_byte = {st.rx_shift[6:0], st.sync2[SFSC_LANE_MOSI]};
      // a read in the same cycle frees the buffer first
      buf_busy = st.rx_full && !rx_read;
   end

   // one process computes the whole next state
   always_comb begin
      next_st = st;
      next_st.sync1 = {slave_select_pin_in, mosi_in, sck_in};
      next_st.sync2 = st.sync1;
      next_st.sck_prev = st.sync2[SFSC_LANE_SCK];

      // firmware writes of zero clear, ones keep; set beats clear
      if (flag_write && !flag_write_mode_fault) begin
         next_st.mode_fault = 1'b0;
      end
      if (flag_write && !flag_write_overrun) begin
         next_st.overrun = 1'b0;
      end
      if (collision) begin
         next_st.mode_fault = 1'b1;
      end

      // receive path: bits taken on the rising clock, mode 0
      if (rx_read) begin
         next_st.rx_full = 1'b0;
      end
      if (!selected) begin
         next_st.bit_cnt = SFSC_FIRST_BIT;
      end else if (sck_rise) begin
         next_st.rx_shift = rx_byte;
         next_st.bit_cnt = st.bit_cnt + SFSC_BIT_STEP;
      end
      if (last_bit) begin
         if (buf_busy) begin
            // unread byte wins; the new one is dropped
            next_st.overrun = 1'b1;
         end else begin
            next_st.rx_data = rx_byte;
            next_st.rx_full = 1'b1;
         end
      end

      // transmit path: hold register feeds the shifter between bytes
      if (tx_write && st.txe) begin
         next_st.tx_hold = tx_data;
         next_st.tx_pending = 1'b1;
         next_st.txe = 1'b0;
      end else if (st.tx_pending && (st.bit_cnt == SFSC_FIRST_BIT)
            && !st.sync2[SFSC_LANE_SCK] && !sck_fall) begin
         next_st.tx_shift = st.tx_hold;
         next_st.tx_pending = 1'b0;
         next_st.txe = 1'b1;
      end else if (selected && sck_fall
            && (st.bit_cnt != SFSC_FIRST_BIT)) begin
         // trailing fall of a byte is skipped so a fresh load survives
         next_st.tx_shift = {st.tx_shift[6:0], 1'b0};
      end
      next_st.miso = next_st.tx_shift[7];
      next_st.miso_oe = selected;

      // select pin role follows the mode field
      case (slave_select_mode_field)
         SFSC_MODE_4W_MST_LOW: begin
            next_st.ss_oe = 1'b1;
            next_st.ss_out = 1'b0;
         end
         SFSC_MODE_4W_MST_HIGH: begin
            next_st.ss_oe = 1'b1;
            next_st.ss_out = 1'b1;
         end
         SFSC_MODE_4W_SLAVE: begin
            next_st.ss_oe = 1'b0;
            next_st.ss_out = SFSC_SS_OUT_RESET;
         end
         default: begin
            next_st.ss_oe = 1'b0;
            next_st.ss_out = SFSC_SS_OUT_RESET;
         end
      endcase

      // request is registered from the next flag values
      next_st.irq = interrupt_enable
         && (next_st.mode_fault || next_st.overrun);
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st.sync1 <= SFSC_SYNC_RESET;
         st.sync2 <= SFSC_SYNC_RESET;
         st.sck_prev <= SFSC_SCK_IDLE; // same as the idle clock level
         st.bit_cnt <= SFSC_FIRST_BIT;
         st.rx_shift <= SFSC_BYTE_RESET;
         st.rx_data <= SFSC_BYTE_RESET;
         st.rx_full <= SFSC_FLAG_RESET;
         st.tx_hold <= SFSC_BYTE_RESET;
         st.tx_pending <= SFSC_FLAG_RESET;
         st.tx_shift <= SFSC_BYTE_RESET;
         st.mode_fault <= SFSC_FLAG_RESET;
         st.overrun <= SFSC_FLAG_RESET;
         st.txe <= SFSC_TXE_RESET;
         st.irq <= SFSC_FLAG_RESET;
         st.ss_out <= SFSC_SS_OUT_RESET;
         st.ss_oe <= 1'b0;
         st.miso <= 1'b0;
         st.miso_oe <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   // outputs taken straight from the state flops
   assign slave_select_pin_out = st.ss_out;
   assign slave_select_pin_oe = st.ss_oe;
   assign miso_out = st.miso;
   assign miso_oe = st.miso_oe;
   assign mode_fault_flag = st.mode_fault;
   assign receive_overrun_flag = st.overrun;
   assign transmit_buffer_empty_status = st.txe;
   assign rx_data = st.rx_data;
   assign rx_full = st.rx_full;
   assign interrupt_request = st.irq;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_mf_set;
      @(posedge clk) disable iff (!rst_n)
      collision |=> st.mode_fault && (st.irq == $past(interrupt_enable));
   endproperty
   a_mf_set: assert property (p_mf_set)
      else $error("mode fault not raised on collision");

   property p_mf_hold;
      @(posedge clk) disable iff (!rst_n)
      st.mode_fault && !(flag_write && !flag_write_mode_fault)
         |=> st.mode_fault;
   endproperty
   a_mf_hold: assert property (p_mf_hold)
      else $error("mode fault cleared without firmware");

   property p_ovr_set;
      @(posedge clk) disable iff (!rst_n)
      last_bit && buf_busy |=> st.overrun && $stable(st.rx_data);
   endproperty
   a_ovr_set: assert property (p_ovr_set)
      else $error("overrun missed or buffer overwritten");

   property p_ovr_slave;
      @(posedge clk) disable iff (!rst_n)
      $rose(st.overrun) |-> !$past(master_enable_bit);
   endproperty
   a_ovr_slave: assert property (p_ovr_slave)
      else $error("overrun raised in master operation");

   property p_ovr_irq;
      @(posedge clk) disable iff (!rst_n)
      st.overrun && interrupt_enable && !flag_write |=> st.irq;
   endproperty
   a_ovr_irq: assert property (p_ovr_irq)
      else $error("overrun did not request interrupt");

   property p_ss_3wire;
      @(posedge clk) disable iff (!rst_n)
      slave_select_mode_field == SFSC_MODE_3WIRE |=> !st.ss_oe;
   endproperty
   a_ss_3wire: assert property (p_ss_3wire)
      else $error("select pin driven in three-wire mode");

   property p_ss_input;
      @(posedge clk) disable iff (!rst_n)
      slave_select_mode_field == SFSC_MODE_4W_SLAVE |=> !st.ss_oe;
   endproperty
   a_ss_input: assert property (p_ss_input)
      else $error("select pin driven in input mode");

   property p_ss_low;
      @(posedge clk) disable iff (!rst_n)
      slave_select_mode_field == SFSC_MODE_4W_MST_LOW
         |=> st.ss_oe && !st.ss_out;
   endproperty
   a_ss_low: assert property (p_ss_low)
      else $error("select pin not driven low");

   property p_ss_high;
      @(posedge clk) disable iff (!rst_n)
      slave_select_mode_field == SFSC_MODE_4W_MST_HIGH
         |=> st.ss_oe && st.ss_out;
   endproperty
   a_ss_high: assert property (p_ss_high)
      else $error("select pin not driven high");

   property p_txe_write;
      @(posedge clk) disable iff (!rst_n)
      tx_write && st.txe |=> !st.txe && (st.tx_hold == $past(tx_data));
   endproperty
   a_txe_write: assert property (p_txe_write)
      else $error("transmit empty not cleared by write");

   property p_flag_clear;
      @(posedge clk) disable iff (!rst_n)
      flag_write && !flag_write_overrun && !last_bit |=> !st.overrun;
   endproperty
   a_flag_clear: assert property (p_flag_clear)
      else $error("overrun not cleared by zero write");

   c_collision: cover property (@(posedge clk) disable iff (!rst_n)
      collision);
   c_byte_in: cover property (@(posedge clk) disable iff (!rst_n)
      last_bit && !buf_busy);
   c_overrun: cover property (@(posedge clk) disable iff (!rst_n)
      last_bit && buf_busy);
   c_tx_load: cover property (@(posedge clk) disable iff (!rst_n)
      $rose(st.txe));

endmodule

// [tb/sfsc_far_master.sv]
// behavioural spi master standing on the far side of the slave port
module sfsc_far_master (
   output logic sck,
   output logic mosi,
   output logic sel_n,
   input wire logic miso
);
   timeunit 1ns;
   timeprecision 100ps;

   // ----
   // idle levels
   // ----
   // clock parked low between frames, select released high
   initial begin
      sck = 1'b0;
      mosi = 1'b0;
      sel_n = 1'b1;
   end

   // select held by the bench, e.g. to force a collision
   task hold_sel(input logic v);
      sel_n = v;
   endtask

   // one byte msb first, miso sampled on the rising edge
   task xfer(input logic [7:0] b, output logic [7:0] got);
      sel_n = 1'b0;
      #125;
      for (int i = 7; i >= 0; i--) begin
         mosi = b[i];
         #62.5 sck = 1'b1;
         got[i] = miso;
         #62.5 sck = 1'b0;
      end
      #250 sel_n = 1'b1;
      // released line must not keep showing the last bit
      mosi = ~mosi;
      // idle gap so back-to-back frames still show a deselect
      #125;
   endtask
endmodule

// [tb/tb_sfsc_core.sv]
// self-checking bench for the fault and slave-select core
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
   err_total++; \
   $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end

module tb_sfsc_core import sfsc_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;

   // ----
   // signals and instances
   // ----
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [1:0] mode = 2'h1;
   logic me, ie, fw_s, fw_mf, fw_ov, rd, tw;
   logic [7:0] td, rxd, got;
   logic sck, mosi, sel_n, sel_w, ss_o, ss_oe, so, so_oe, miso_w;
   logic mf, ov, txe, rxf, irq;
   int err_total = 0;
   int n_compared = 0;
   int cyc = 0;

   always #4 clk = ~clk;
   // wire level: the core wins while it drives the select pin
   assign sel_w = ss_oe ? ss_o : sel_n;
   // undriven data line shows the inverse, so a missing enable shows up
   assign miso_w = so_oe ? so : ~so;

   sfsc_core i_sfsc_core (
      .clk(clk), .reset_n(reset_n),
      .slave_select_mode_field(mode), .master_enable_bit(me),
      .interrupt_enable(ie), .flag_write(fw_s),
      .flag_write_mode_fault(fw_mf), .flag_write_overrun(fw_ov),
      .rx_read(rd), .tx_write(tw), .tx_data(td),
      .sck_in(sck), .mosi_in(mosi), .slave_select_pin_in(sel_w),
      .slave_select_pin_out(ss_o), .slave_select_pin_oe(ss_oe),
      .miso_out(so), .miso_oe(so_oe), .mode_fault_flag(mf),
      .receive_overrun_flag(ov), .transmit_buffer_empty_status(txe),
      .rx_data(rxd), .rx_full(rxf), .interrupt_request(irq)
   );

   sfsc_far_master i_sfsc_far_master (
      .sck(sck), .mosi(mosi), .sel_n(sel_n), .miso(miso_w)
   );

   // ----
   // helpers
   // ----
   // firmware-side inputs move 1 ns after the edge, except rd right after a transfer, and never on it; far-master pin delays can land on a clock edge
   task step;
      @(posedge clk);
      #1;
   endtask

   // firmware flag write; one keeps a flag, zero clears it
   task fw(input logic m, input logic o);
      fw_s = 1'b1;
      fw_mf = m;
      fw_ov = o;
      step();
      fw_s = 1'b0;
      fw_mf = 1'b1;
      fw_ov = 1'b1;
   endtask

   task rd_pulse;
      rd = 1'b1;
      step();
      rd = 1'b0;
   endtask

   task print_verdict;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ----
   // scenarios
   // ----
   task t_reset;
      `CHK(txe, 1'b1)
      `CHK(ss_oe, 1'b0)
      `CHK(mf, 1'b0)
      `CHK(ov, 1'b0)
      `CHK(so_oe, 1'b0)
      `CHK(irq, 1'b0)
      $display("test reset done");
   endtask

   task t_modes;
      for (int m = 0; m < 4; m++) begin
         mode = m[1:0];
         step();
         step();
         `CHK(ss_oe, m > 1)
         if (m > 1) `CHK(ss_o, m == 3)
      end
      $display("test modes done");
   endtask

   task t_tx;
      mode = SFSC_MODE_4W_SLAVE;
      me = 1'b0;
      tw = 1'b1;
      td = 8'h96;
      step();
      tw = 1'b0;
      `CHK(txe, 1'b0)
      for (int k = 0; k < 4 && txe !== 1'b1; k++) step();
      `CHK(txe, 1'b1)
      `CHK(so, 1'b1)
      `CHK(so_oe, 1'b0)
      i_sfsc_far_master.xfer(8'h5A, got);
      `CHK(got, 8'h96)
      `CHK(rxf, 1'b1)
      `CHK(rxd, 8'h5A)
      rd_pulse();
      $display("test transmit done");
   endtask

   // second byte lands on an unread buffer and is dropped
   task t_rx;
      i_sfsc_far_master.xfer(8'hA5, got);
      step();
      `CHK(rxf, 1'b1)
      `CHK(ov, 1'b0)
      i_sfsc_far_master.xfer(8'h3C, got);
      step();
      `CHK(ov, 1'b1)
      `CHK(rxd, 8'hA5)
      `CHK(irq, 1'b1)
      fw(1'b1, 1'b1);
      repeat (10) step();
      `CHK(ov, 1'b1)
      fw(1'b1, 1'b0);
      `CHK(ov, 1'b0)
      step();
      `CHK(irq, 1'b0)
      rd_pulse();
      $display("test receive done");
   endtask

   task t_master;
      mode = SFSC_MODE_3WIRE;
      me = 1'b1;
      i_sfsc_far_master.xfer(8'h11, got);
      i_sfsc_far_master.xfer(8'h22, got);
      step();
      `CHK(ov, 1'b0)
      `CHK(rxf, 1'b0)
      $display("test master done");
   endtask

   task t_fault;
      mode = SFSC_MODE_4W_SLAVE;
      i_sfsc_far_master.hold_sel(1'b0);
      repeat (4) step();
      `CHK(mf, 1'b1)
      `CHK(irq, 1'b1)
      i_sfsc_far_master.hold_sel(1'b1);
      me = 1'b0;
      repeat (20) step();
      `CHK(mf, 1'b1)
      ie = 1'b0;
      repeat (2) step();
      `CHK(irq, 1'b0)
      fw(1'b0, 1'b1);
      `CHK(mf, 1'b0)
      $display("test fault done");
   endtask

   // ----
   // run control
   // ----
   // about a thousand cycles suffice; the ceiling cuts a hang
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         print_verdict();
      end
   end

   initial begin
      me = 1'b0;
      ie = 1'b1;
      fw_s = 1'b0;
      fw_mf = 1'b1;
      fw_ov = 1'b1;
      rd = 1'b0;
      tw = 1'b0;
      td = 8'h00;
      repeat (2) @(posedge clk);
      #1 reset_n = 1'b1;
      repeat (5) step();
      t_reset();
      t_modes();
      t_tx();
      t_rx();
      t_master();
      t_fault();
      print_verdict();
   end
endmodule
